// File: src/event_counter_filter.v
// event counter with threshold, edge filter, cascade start and register port
`include "event_counter_filter_map.vh"
`timescale 1ns/1ps
`default_nettype none

module event_counter_filter
#(
    parameter CNT_W     = 40,
    parameter SEL_W     = 3,
    parameter [2:0] SEL_INDEX = 3'h0
)
(
    input  wire                   ref_clk,
    input  wire                   rst_n,
    input  wire [`ECF_ADDR_W-1:0] regAddr,
    input  wire [31:0]            regWrData,
    input  wire                   regWrEn,
    input  wire                   regRdEn,
    output reg  [31:0]            regRdData,
    input  wire [3:0]             eventLines,
    input  wire                   userMode,
    input  wire                   altOverflow,
    output reg                    overflowPulse,
    output reg                    running,
    output reg                    irq
);

    reg  [31:0]            evSel_q;
    reg  [31:0]            cfg_q;
    reg  [CNT_W-1:0]       count_q;
    reg  [`ECF_ST_W-1:0]   status_q;
    reg  [`ECF_ST_W-1:0]   mask_q;
    reg                    cascStarted_q;
    reg                    prevPass_q;

    wire                   enFlag    = cfg_q[`ECF_CFG_ENABLE_BIT];
    wire [SEL_W-1:0]       selField  = cfg_q[`ECF_CFG_SEL_MSB:`ECF_CFG_SEL_LSB];
    wire                   cmpFlag   = cfg_q[`ECF_CFG_CMP_BIT];
    wire                   cplFlag   = cfg_q[`ECF_CFG_CPL_BIT];
    wire [3:0]             threshold = cfg_q[`ECF_CFG_THR_MSB:`ECF_CFG_THR_LSB];
    wire                   edgeFlag  = cfg_q[`ECF_CFG_EDGE_BIT];
    wire                   cascFlag  = cfg_q[`ECF_CFG_CASC_BIT];
    wire                   userFlag  = evSel_q[`ECF_EVSEL_USER_BIT];
    wire                   supvFlag  = evSel_q[`ECF_EVSEL_SUPV_BIT];

    // write decode shared by several processes; reads decode in their own case
    function hit;
        input [`ECF_ADDR_W-1:0] a;
        input [`ECF_ADDR_W-1:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    wire                   wrEvSel  = regWrEn && hit(regAddr, `ECF_OFS_EVSEL);
    wire                   wrCfg    = regWrEn && hit(regAddr, `ECF_OFS_CFG);
    wire                   wrCntLo  = regWrEn && hit(regAddr, `ECF_OFS_CNT_LO);
    wire                   wrCntHi  = regWrEn && hit(regAddr, `ECF_OFS_CNT_HI);
    wire                   wrStatus = regWrEn && hit(regAddr, `ECF_OFS_STATUS);
    wire                   wrMask   = regWrEn && hit(regAddr, `ECF_OFS_MASK);

    // the index, not an address, picks the selection register feeding us
    wire                   selOk    = (selField == SEL_INDEX[SEL_W-1:0]);

    // events only count at privilege levels that software allowed
    wire                   privOk   = userMode ? userFlag : supvFlag;

    // cascade start holds only while the cascade flag stays set
    wire                   cascRun  = cascStarted_q && cascFlag;
    wire                   active   = (enFlag || cascRun) && selOk;

    // lines taken as one binary value: line n weighs 2**n
    localparam             N_LINES  = 4;
    wire [N_LINES-1:0]     inValue;
    genvar                 gl;

    generate
        for (gl = 0; gl < N_LINES; gl = gl + 1)
        begin : g_weight
            assign inValue[gl] = eventLines[gl];
        end
    endgenerate

    reg                    pass;

    // threshold compare; the sense flag picks which side passes
    always @*
    begin
        if (cplFlag)
            pass = (inValue <= threshold);
        else
            pass = (inValue > threshold);
    end

    // reset clears the memory, so a pass right after reset counts as an edge
    wire                   edgeHit  = pass && !prevPass_q;

    // privilege and select gate the increment, never the edge memory
    reg  [3:0]             inc;

    always @*
    begin
        if (!active || !privOk)
            inc = 4'h0;
        else if (!cmpFlag)
            inc = inValue;
        else if (edgeFlag)
            inc = {3'b000, edgeHit};
        else
            inc = {3'b000, pass};
    end

    // increment widened to the count, plus one carry bit for the wrap
    wire [CNT_W:0]         incWide  = {{(CNT_W-3){1'b0}}, inc};
    wire [CNT_W:0]         sum      = {1'b0, count_q} + incWide;
    wire                   wrapped  = sum[CNT_W];
    wire [CNT_W-1:0]       cntWrLo  = {count_q[CNT_W-1:32], regWrData};
    wire [CNT_W-1:0]       cntWrHi  = {regWrData[CNT_W-33:0], count_q[31:0]};

    // configuration registers; new values steer logic from the next cycle
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            evSel_q <= `ECF_EVSEL_RESET;
        else if (wrEvSel)
            evSel_q <= regWrData & `ECF_EVSEL_RW_MASK;
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            cfg_q <= `ECF_CFG_RESET;
        else if (wrCfg)
            cfg_q <= regWrData & `ECF_CFG_RW_MASK;
    end

    // mask write lands at once; irq follows one cycle later
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            mask_q <= {`ECF_ST_W{1'b0}};
        else if (wrMask)
            mask_q <= regWrData[`ECF_ST_W-1:0];
    end

    reg  [CNT_W-1:0]       count_d;

    // a software write to a count word beats that cycle's increment
    // the two words are written one at a time, so stop the counter first
    always @*
    begin
        count_d = sum[CNT_W-1:0];
        if (wrCntLo)
            count_d = cntWrLo;
        else if (wrCntHi)
            count_d = cntWrHi;
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            count_q <= {CNT_W{1'b0}};
        else
            count_q <= count_d;
    end

    // edge memory follows the threshold result every cycle, count or not
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            prevPass_q <= 1'b0;
        else
            prevPass_q <= pass;
    end

    reg                    cascStarted_d;

    // cascade start latch, dropped as soon as the cascade flag is cleared
    always @*
    begin
        cascStarted_d = cascStarted_q;
        if (!cascFlag)
            cascStarted_d = 1'b0;
        else if (altOverflow)
            cascStarted_d = 1'b1;
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            cascStarted_q <= 1'b0;
        else
            cascStarted_q <= cascStarted_d;
    end

    // a wrap in a count word write cycle is not flagged
    wire                   ovfEvt   = wrapped && !wrCntLo && !wrCntHi;
    wire                   cascEvt  = cascFlag && altOverflow && !cascStarted_q;
    wire [`ECF_ST_W-1:0]   stSet    = {cascEvt, ovfEvt};
    wire [`ECF_ST_W-1:0]   stClr    = wrStatus ? regWrData[`ECF_ST_W-1:0] : {`ECF_ST_W{1'b0}};
    wire [`ECF_ST_W-1:0]   status_d;

    // sticky bit next value; a new event in the clearing cycle is kept
    function sticky;
        input qIn;
        input setIn;
        input clrIn;
        begin
            sticky = setIn | (qIn & ~clrIn);
        end
    endfunction

    genvar                 gs;

    // one sticky flop per status bit
    generate
        for (gs = 0; gs < `ECF_ST_W; gs = gs + 1)
        begin : g_status
            assign status_d[gs] = sticky(status_q[gs], stSet[gs], stClr[gs]);

            always @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                    status_q[gs] <= 1'b0;
                else
                    status_q[gs] <= status_d[gs];
            end
        end
    endgenerate

    wire                   irqNext  = |(status_d & mask_q);

    // outputs straight from flip-flops; irq follows the status being stored
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= irqNext;
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            overflowPulse <= 1'b0;
        else
            overflowPulse <= ovfEvt;
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            running <= 1'b0;
        else
            running <= active;
    end

    reg  [31:0]            rdMux;

    always @*
    begin
        rdMux = 32'h00000000;
        case (regAddr)
            `ECF_OFS_EVSEL:  rdMux = evSel_q;
            `ECF_OFS_CFG:    rdMux = cfg_q;
            `ECF_OFS_CNT_LO: rdMux = count_q[31:0];
            `ECF_OFS_CNT_HI: rdMux = {{(64-CNT_W){1'b0}}, count_q[CNT_W-1:32]};
            `ECF_OFS_STATUS: rdMux = {{(32-`ECF_ST_W){1'b0}}, status_q};
            `ECF_OFS_MASK:   rdMux = {{(32-`ECF_ST_W){1'b0}}, mask_q};
            default:         rdMux = 32'h00000000;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            regRdData <= 32'h00000000;
        else if (regRdEn)
            regRdData <= rdMux;
        else
            regRdData <= 32'h00000000;
    end

endmodule // event_counter_filter

`default_nettype wire

// File: src/event_counter_filter_map.vh
// register offsets, field positions, reset values of the event counter filter
`ifndef EVENT_COUNTER_FILTER_MAP_VH
`define EVENT_COUNTER_FILTER_MAP_VH

// register byte offsets
`define ECF_ADDR_W          8
`define ECF_OFS_EVSEL       8'h00
`define ECF_OFS_CFG         8'h04
`define ECF_OFS_CNT_LO      8'h08
`define ECF_OFS_CNT_HI      8'h0C
`define ECF_OFS_STATUS      8'h10
`define ECF_OFS_MASK        8'h14

// event selection register fields
`define ECF_EVSEL_USER_BIT  2
`define ECF_EVSEL_SUPV_BIT  3
`define ECF_EVSEL_MASK_LSB  9
`define ECF_EVSEL_MASK_MSB  24
`define ECF_EVSEL_CODE_LSB  25
`define ECF_EVSEL_CODE_MSB  31
`define ECF_EVSEL_RW_MASK   32'hFFFFFE0C
`define ECF_EVSEL_RESET     32'h00000000

// counter configuration register fields
`define ECF_CFG_ENABLE_BIT  12
`define ECF_CFG_SEL_LSB     13
`define ECF_CFG_SEL_MSB     15
`define ECF_CFG_CMP_BIT     18
`define ECF_CFG_CPL_BIT     19
`define ECF_CFG_THR_LSB     20
`define ECF_CFG_THR_MSB     23
`define ECF_CFG_EDGE_BIT    24
`define ECF_CFG_CASC_BIT    30
`define ECF_CFG_RW_MASK     32'h41FCF000
`define ECF_CFG_RESET       32'h00000000

// status and mask bits
`define ECF_ST_OVF_BIT      0
`define ECF_ST_CASC_BIT     1
`define ECF_ST_W            2

`endif

// File: test/event_source.sv
// event line source standing in for the processor event logic
`timescale 1ns/1ps
`default_nettype none
module event_source #(
    parameter logic [31:0] SEQ = 32'h0
) (
    input  wire logic       ref_clk,
    input  wire logic       go,
    input  wire logic [3:0] idleVal,
    output logic [3:0]      eventLines
);
    int step = 8;
    always @(posedge ref_clk)
        step <= go ? 0 : (step < 8 ? step + 1 : 8);
    // idle value is picked to fail the filter, so only the burst can count
    assign eventLines = step < 8 ? SEQ[step*4 +: 4] : idleVal;
endmodule // event_source
`default_nettype wire

// File: test/event_counter_filter_properties.sv
// port assertions for the event counter filter
`timescale 1ns/1ps
`default_nettype none
module event_counter_filter_properties (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWrData,
    input wire logic        regWrEn,
    input wire logic        regRdEn,
    input wire logic [31:0] regRdData,
    input wire logic        altOverflow,
    input wire logic        overflowPulse,
    input wire logic        running,
    input wire logic        irq
);
    logic [31:0] cfgQ;
    logic [31:0] maskQ;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // shadow copies, so cause and effect can be tied without the bodies
    always_ff @(posedge ref_clk or negedge rst_n)
        if (!rst_n) {cfgQ, maskQ} <= 64'h0;
        else if (regWrEn && regAddr == 8'h04) cfgQ <= regWrData;
        else if (regWrEn && regAddr == 8'h14) maskQ <= regWrData;
    sequence s_start;
        regWrEn && regAddr == 8'h04 && regWrData[12] && regWrData[15:13] == 3'h0;
    endsequence
    sequence s_stop;
        regWrEn && regAddr == 8'h04 && !regWrData[12] && !regWrData[30];
    endsequence
    a_read_idle: assert property (!$past(regRdEn) |-> regRdData == 32'h0)
        else $error("read data outside its cycle");
    a_read_unmapped: assert property (regRdEn && regAddr > 8'h14 |=> regRdData == 32'h0)
        else $error("unmapped read not zero");
    a_enable_start: assert property (s_start |-> ##2 running)
        else $error("enable did not start");
    a_disable_stop: assert property (s_stop |-> ##2 !running)
        else $error("clear did not stop");
    a_cascade_start: assert property (altOverflow && cfgQ[30] && cfgQ[15:13] == 3'h0
        |-> ##[1:2] running)
        else $error("cascade did not start");
    a_ovf_single: assert property (overflowPulse |=> !overflowPulse)
        else $error("overflow pulse too long");
    a_ovf_irq: assert property (overflowPulse && maskQ[0] |-> ##[0:2] irq)
        else $error("overflow raised no irq");
    a_irq_masked: assert property (maskQ == 32'h0 && $past(maskQ) == 32'h0 |-> !irq)
        else $error("irq while all masked");
endmodule // event_counter_filter_properties
`default_nettype wire

// File: test/tb_event_counter_filter.sv
// self-checking bench for the event counter filter
`timescale 1ns/1ps
`default_nettype none
module tb_event_counter_filter;
    localparam logic [31:0] SEQ = 32'h83F90775;
    localparam logic [31:0] CFGS [6] = '{32'h1000, 32'h01001000, 32'h00641000,
        32'h006C1000, 32'h01241000, 32'h3000};
    logic ref_clk = 1'b0, rst_n = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
    logic userMode = 1'b0, altOverflow = 1'b0, go = 1'b0, sawOvf = 1'b0;
    logic overflowPulse, running, irq;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0, regRdData;
    logic [3:0] idleVal = 4'h0, eventLines;
    int failures = 0, numChecks = 0;
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (overflowPulse) sawOvf <= 1'b1;
    event_counter_filter u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .eventLines(eventLines), .userMode(userMode), .altOverflow(altOverflow),
        .overflowPulse(overflowPulse), .running(running), .irq(irq));
    event_source #(.SEQ(SEQ)) u_src (.ref_clk(ref_clk), .go(go), .idleVal(idleVal),
        .eventLines(eventLines));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        numChecks++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // a spare cycle after each strobe keeps every assignment to one per step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge ref_clk);
        regWrEn <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge ref_clk);
        regRdEn <= 1'b0;
        #1 chk(regRdData, exp, what);
        @(posedge ref_clk);
    endtask
    function automatic logic [31:0] model(input logic [31:0] e, input logic [31:0] c);
        logic p;
        logic q;
        logic [31:0] n;
        n = 32'h0;
        q = 1'b0;
        if (c[15:13] != 3'h0 || !(userMode ? e[2] : e[3]))
            return n;
        for (int i = 0; i < 8; i++)
        begin
            p = c[19] ? SEQ[i*4 +: 4] <= c[23:20] : SEQ[i*4 +: 4] > c[23:20];
            if (!c[18]) n += SEQ[i*4 +: 4];
            else if (p && !(c[24] && q)) n += 1;
            q = p;
        end
        return n;
    endfunction
    task automatic run(input logic [31:0] e, input logic [31:0] c, input logic full);
        wr(8'h00, e);
        wr(8'h08, {32{full}});
        wr(8'h0C, {24'h0, {8{full}}});
        idleVal <= (c[18] && c[19]) ? 4'hF : 4'h0;
        wr(8'h04, c);
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (12) @(posedge ref_clk);
        wr(8'h04, 32'h0);
        repeat (4) @(posedge ref_clk);
        rd(8'h08, model(e, c) - full, "count");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", numChecks, failures);
        if (failures == 0 && numChecks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        #20000;
        failures++;
        conclude;
    end
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        wr(8'h00, 32'hFFFFFFFF);
        rd(8'h00, 32'hFFFFFE0C, "evsel");
        wr(8'h04, 32'hFFFFEFFF);
        rd(8'h04, 32'h41FCE000, "config");
        rd(8'h20, 32'h0, "unmapped");
        $display("fields done");
        foreach (CFGS[i])
            run(32'hC, CFGS[i], 1'b0);
        userMode <= 1'b1;
        run(32'h8, 32'h1000, 1'b0);
        $display("filters done");
        wr(8'h14, 32'h1);
        run(32'hC, 32'h1000, 1'b1);
        chk(sawOvf, 1'b1, "ovf pulse");
        chk(irq, 1'b1, "irq");
        rd(8'h10, 32'h1, "status");
        rd(8'h0C, 32'h0, "count high");
        wr(8'h14, 32'h0);
        @(posedge ref_clk);
        chk(irq, 1'b0, "irq masked");
        rd(8'h14, 32'h0, "mask");
        wr(8'h14, 32'h1);
        wr(8'h10, 32'h1);
        rd(8'h10, 32'h0, "cleared");
        chk(irq, 1'b0, "irq off");
        $display("wrap done");
        wr(8'h04, 32'h40000000);
        altOverflow <= 1'b1;
        @(posedge ref_clk);
        altOverflow <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk(running, 1'b1, "cascade");
        chk(irq, 1'b0, "masked");
        wr(8'h14, 32'h3);
        @(posedge ref_clk);
        chk(irq, 1'b1, "unmasked");
        wr(8'h04, 32'h0);
        repeat (2) @(posedge ref_clk);
        chk(running, 1'b0, "stopped");
        $display("cascade done");
        conclude;
    end
endmodule // tb_event_counter_filter
bind event_counter_filter event_counter_filter_properties u_props (.ref_clk(ref_clk),
    .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .altOverflow(altOverflow),
    .overflowPulse(overflowPulse), .running(running), .irq(irq));
`default_nettype wire
